// ### ebe_bus_port.sv
// External bus emulation port: bus cycle sequencer, strobes, wait states and port emulation
//
// Behaviour
// - The region flag goes low while the accessed location lies in 4096 to 65407.
// - The address bus is driven during memory accesses, including locations 0 to 4095.
// - Data moves over an 8-bit two-way bus with separate in, out and enable signals.
// - The wait input is sampled at the end of the second bus state of a read or write.
// - An active sampled wait enters the wait state, repeated while wait stays active.
// - The fetch indicator is high through an opcode fetch cycle and low otherwise.
// - The write strobe is low only while valid write data is on the data bus.
// - The write strobe is released while halted, under bus hold and in reset.
// - The read strobe goes low so that the far device drives its data onto the bus.
// - The read strobe is released while halted, under bus hold and in reset.
// - The first port instruction drives the pair on the address bus and code 01h on data.
// - The second port instruction drives the pair on the address bus and code 02h on data.
// - The third port instruction releases the address bus and drives code 04h on data.
// - The emulation strobe is active for one cycle, in the second bus state of each of the three port instructions.
`timescale 1ns/100ps
`default_nettype none
`include "ebe_consts.svh"

module ebe_bus_port (
    input  wire logic                   clk_i,
    input  wire logic                   rst_n_i,
    // Core side request
    input  wire logic                   req_valid_i,
    output logic                        req_ready_o,
    input  wire logic [2:0]             req_op_i,
    input  wire logic [`EBE_ADDR_W-1:0] req_addr_i,
    input  wire logic [`EBE_DATA_W-1:0] req_wdata_i,
    input  wire logic [7:0]             pair_upper_i,
    input  wire logic [7:0]             pair_lower_i,
    input  wire logic                   halt_i,
    input  wire logic                   hold_i,
    output logic [`EBE_DATA_W-1:0]      rdata_o,
    output logic                        rdata_valid_o,
    output logic                        bus_released_o,
    // Pins
    output logic [`EBE_ADDR_W-1:0]      address_bus_lines_o,
    output logic                        address_bus_lines_oe_n_o,
    input  wire logic [`EBE_DATA_W-1:0] data_bus_lines_i,
    output logic [`EBE_DATA_W-1:0]      data_bus_lines_o,
    output logic                        data_bus_lines_oe_n_o,
    output logic                        rd_n_o,
    output logic                        rd_oe_n_o,
    output logic                        wr_n_o,
    output logic                        wr_oe_n_o,
    input  wire logic                   wait_n_i,
    output logic                        opcode_fetch_indicator_o,
    output logic                        external_region_flag_n_o,
    output logic                        emulation_strobe_o
);

    ebe_pkg::ebe_state_t        state_q;
    ebe_pkg::ebe_state_t        state_d;
    logic [2:0]                 op_q;
    logic [`EBE_ADDR_W-1:0]     addr_q;
    logic [`EBE_DATA_W-1:0]     wdata_q;
    logic                       wait_meta_q;
    logic                       wait_sync_q;
    logic [`EBE_DATA_W-1:0]     din_meta_q;
    logic [`EBE_DATA_W-1:0]     din_sync_q;
    logic                       accept;
    logic [2:0]                 op_cur;
    logic [`EBE_ADDR_W-1:0]     addr_cur;
    logic [`EBE_DATA_W-1:0]     wdata_cur;
    logic                       in_cycle;
    logic                       strobe_phase;
    logic                       is_fetch;
    logic                       is_rd;
    logic                       is_wr;
    logic                       is_emul;
    logic                       rel_addr;
    logic [`EBE_DATA_W-1:0]     emul_code;
    logic                       ext_hit;
    logic                       park;
    logic [`EBE_ADDR_W-1:0]     addr_q_o;
    logic                       addr_oe_n_q;
    logic [`EBE_DATA_W-1:0]     dout_q;
    logic                       dout_oe_n_q;
    logic                       rd_n_q;
    logic                       rd_oe_n_q;
    logic                       wr_n_q;
    logic                       wr_oe_n_q;
    logic                       fetch_q;
    logic                       ext_n_q;
    logic                       stb_q;
    logic [`EBE_DATA_W-1:0]     rdata_q;
    logic                       rvalid_q;
    logic                       rd_done_q;
    logic                       released_q;

    // Request handshake: new cycles only from idle and never under halt or hold
    assign req_ready_o = (state_q == ebe_pkg::ST_IDLE) && !halt_i && !hold_i;
    assign accept      = req_ready_o && req_valid_i;
    assign op_cur      = accept ? req_op_i : op_q;
    assign wdata_cur   = accept ? req_wdata_i : wdata_q;
    assign addr_cur    = accept ? ((req_op_i == ebe_pkg::OP_PAIR_ONE || req_op_i == ebe_pkg::OP_PAIR_TWO)
                                   ? {pair_upper_i, pair_lower_i} : req_addr_i) : addr_q;

    // Pin synchronisers for wait and read data
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wait_meta_q <= 1'b1;
            wait_sync_q <= 1'b1;
            din_meta_q  <= `EBE_DATA_RST;
            din_sync_q  <= `EBE_DATA_RST;
        end else begin
            wait_meta_q <= wait_n_i;
            wait_sync_q <= wait_meta_q;
            din_meta_q  <= data_bus_lines_i;
            din_sync_q  <= din_meta_q;
        end
    end

    // Captured request
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            op_q    <= ebe_pkg::OP_READ;
            addr_q  <= `EBE_ADDR_RST;
            wdata_q <= `EBE_DATA_RST;
        end else if (accept) begin
            op_q    <= req_op_i;
            addr_q  <= addr_cur;
            wdata_q <= req_wdata_i;
        end
    end

    // Instruction and region decoders
    ebe_port_emul ebe_port_emul_inst (
        .op_i           (op_cur),
        .is_emul_o      (is_emul),
        .release_addr_o (rel_addr),
        .code_o         (emul_code)
    );

    ebe_region_decode ebe_region_decode_inst (
        .addr_i    (addr_cur),
        .ext_hit_o (ext_hit)
    );

    assign is_fetch = (op_cur == ebe_pkg::OP_FETCH);
    assign is_rd    = is_fetch || (op_cur == ebe_pkg::OP_READ);
    assign is_wr    = (op_cur == ebe_pkg::OP_WRITE);

    // Bus cycle sequencer
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ebe_pkg::ST_IDLE: begin
                if (accept && (is_rd || is_wr || is_emul)) begin
                    state_d = ebe_pkg::ST_T1;
                end
            end
            ebe_pkg::ST_T1: begin
                state_d = ebe_pkg::ST_SECOND;
            end
            ebe_pkg::ST_SECOND: begin
                // wait sampled at end of the second state
                if (!wait_sync_q && (is_rd || is_wr)) begin
                    state_d = ebe_pkg::ST_WAIT;
                end else begin
                    state_d = ebe_pkg::ST_T3;
                end
            end
            ebe_pkg::ST_WAIT: begin
                if (wait_sync_q) begin
                    state_d = ebe_pkg::ST_T3;
                end
            end
            ebe_pkg::ST_T3: begin
                state_d = ebe_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= ebe_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    assign in_cycle     = (state_d != ebe_pkg::ST_IDLE);
    assign strobe_phase = (state_d == ebe_pkg::ST_SECOND) || (state_d == ebe_pkg::ST_WAIT) ||
                          (state_d == ebe_pkg::ST_T3);
    assign park         = (halt_i || hold_i) && !in_cycle;

    // Address bus and region flag
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            addr_q_o    <= `EBE_ADDR_RST;
            addr_oe_n_q <= 1'b1;
            ext_n_q     <= 1'b1;
        end else begin
            addr_q_o    <= addr_cur;
            addr_oe_n_q <= !(in_cycle && !rel_addr);
            ext_n_q     <= !(in_cycle && (is_rd || is_wr) && ext_hit);
        end
    end

    // Data bus out: write data or port code
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dout_q      <= `EBE_DATA_RST;
            dout_oe_n_q <= 1'b1;
        end else begin
            dout_q      <= is_emul ? emul_code : wdata_cur;
            dout_oe_n_q <= !(in_cycle && (is_wr || is_emul));
        end
    end

    // Read and write strobes with release under halt and hold
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_n_q    <= 1'b1;
            rd_oe_n_q <= 1'b1;
            wr_n_q    <= 1'b1;
            wr_oe_n_q <= 1'b1;
        end else begin
            // read strobe from second state to T3
            rd_n_q    <= !(in_cycle && is_rd && strobe_phase);
            // write strobe only inside the data window
            wr_n_q    <= !(in_cycle && is_wr && strobe_phase);
            rd_oe_n_q <= park;
            wr_oe_n_q <= park;
        end
    end

    // Fetch indicator and emulation strobe
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fetch_q <= 1'b0;
            stb_q   <= 1'b0;
        end else begin
            fetch_q <= in_cycle && is_fetch;
            // strobe during second state of a port instruction
            stb_q   <= is_emul && (state_d == ebe_pkg::ST_SECOND);
        end
    end

    // Read data capture one cycle after T3: the pin synchroniser lags two cycles, so this takes a strobed value
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q    <= `EBE_DATA_RST;
            rd_done_q  <= 1'b0;
            rvalid_q   <= 1'b0;
            released_q <= 1'b1;
        end else begin
            rd_done_q  <= (state_q == ebe_pkg::ST_T3) && is_rd;
            rvalid_q   <= rd_done_q;
            released_q <= park;
            if (rd_done_q) begin
                rdata_q <= din_sync_q;
            end
        end
    end

    assign address_bus_lines_o      = addr_q_o;
    assign address_bus_lines_oe_n_o = addr_oe_n_q;
    assign data_bus_lines_o         = dout_q;
    assign data_bus_lines_oe_n_o    = dout_oe_n_q;
    assign rd_n_o                   = rd_n_q;
    assign rd_oe_n_o                = rd_oe_n_q;
    assign wr_n_o                   = wr_n_q;
    assign wr_oe_n_o                = wr_oe_n_q;
    assign opcode_fetch_indicator_o = fetch_q;
    assign external_region_flag_n_o = ext_n_q;
    assign emulation_strobe_o       = stb_q;
    assign rdata_o                  = rdata_q;
    assign rdata_valid_o            = rvalid_q;
    assign bus_released_o           = released_q;

    // Checks next to the logic
    a_ext_in_range:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !ext_n_q |-> (addr_q_o >= `EBE_EXT_LO) && (addr_q_o <= `EBE_EXT_HI) && !addr_oe_n_q)
    else $error("Region flag low outside emulated region");

    a_ext_outside:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (addr_q_o < `EBE_EXT_LO || addr_q_o > `EBE_EXT_HI) |-> ext_n_q)
    else $error("Region flag low for internal location");

    a_addr_low_drive:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (!rd_n_q && addr_q_o <= `EBE_INT_TOP) |-> !addr_oe_n_q)
    else $error("Address bus not driven for low location");

    a_wait_sample:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state_q == ebe_pkg::ST_SECOND && !wait_sync_q && !rd_n_q) |=> (state_q == ebe_pkg::ST_WAIT) && !rd_n_q)
    else $error("Wait at end of second state did not enter wait state");

    a_wait_repeat:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state_q == ebe_pkg::ST_WAIT) |=> (($past(wait_sync_q) == 1'b0) ? state_q == ebe_pkg::ST_WAIT
                                                                    : state_q == ebe_pkg::ST_T3))
    else $error("Wait state not held or not left correctly");

    a_fetch_flag:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state_q != ebe_pkg::ST_IDLE) |-> (fetch_q == (op_q == ebe_pkg::OP_FETCH)))
    else $error("Fetch indicator does not match cycle kind");

    a_write_data:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !wr_n_q |-> !dout_oe_n_q && (dout_q == wdata_q) && $past(!dout_oe_n_q))
    else $error("Write strobe without valid data");

    a_strobe_park:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ((halt_i || hold_i) && state_q == ebe_pkg::ST_IDLE) |=> wr_oe_n_q && rd_oe_n_q)
    else $error("Strobes still driven while parked");

    a_read_start:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $fell(rd_n_q) |-> (state_q == ebe_pkg::ST_SECOND) && !addr_oe_n_q)
    else $error("Read strobe fell outside second state");

    a_code_one:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (stb_q && op_q == ebe_pkg::OP_PAIR_ONE) |-> (dout_q == `EBE_CODE_ONE) && !addr_oe_n_q)
    else $error("First port instruction wrong code");

    a_code_two:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (stb_q && op_q == ebe_pkg::OP_PAIR_TWO) |-> (dout_q == `EBE_CODE_TWO) && !addr_oe_n_q)
    else $error("Second port instruction wrong code");

    a_code_four:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (stb_q && op_q == ebe_pkg::OP_REL_FOUR) |-> (dout_q == `EBE_CODE_FOUR) && addr_oe_n_q)
    else $error("Third port instruction wrong code or address driven");

    a_strobe_span:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(stb_q) |-> !dout_oe_n_q ##1 !stb_q ##1 (state_q == ebe_pkg::ST_IDLE))
    else $error("Emulation strobe not one cycle in second state");

endmodule // ebe_bus_port
`default_nettype wire

// ### ebe_consts.svh
// Constants of the external bus emulation port: bus widths, region bounds and port codes
`ifndef EBE_CONSTS_SVH
`define EBE_CONSTS_SVH

// Bus widths
`define EBE_ADDR_W      16
`define EBE_DATA_W      8

// Highest location kept as an internal reference below the emulated region
`define EBE_INT_TOP     16'h0FFF
// Emulated external region bounds, inclusive
`define EBE_EXT_LO      16'h1000
`define EBE_EXT_HI      16'hFF7F

// Codes put on the data bus by the emulated port instructions
`define EBE_CODE_ONE    8'h01
`define EBE_CODE_TWO    8'h02
`define EBE_CODE_FOUR   8'h04

// Reset values of the bus outputs
`define EBE_ADDR_RST    16'h0000
`define EBE_DATA_RST    8'h00

`endif

// ### ebe_pkg.sv
// Types of the external bus emulation port
package ebe_pkg;

    // Bus cycle states, one-hot
    typedef enum logic [4:0] {
        ST_IDLE   = 5'h01,
        ST_T1     = 5'h02,
        ST_SECOND = 5'h04,
        ST_WAIT   = 5'h08,
        ST_T3     = 5'h10
    } ebe_state_t;

    // Access kinds requested by the core
    typedef enum logic [2:0] {
        OP_FETCH    = 3'h0,
        OP_READ     = 3'h1,
        OP_WRITE    = 3'h2,
        OP_PAIR_ONE = 3'h3,
        OP_PAIR_TWO = 3'h4,
        OP_REL_FOUR = 3'h5
    } ebe_op_t;

endpackage

// ### ebe_region_decode.sv
// Address region decode for the emulated external memory flag
`timescale 1ns/100ps
`default_nettype none
`include "ebe_consts.svh"

module ebe_region_decode (
    input  wire logic [`EBE_ADDR_W-1:0] addr_i,
    output logic                        ext_hit_o
);

    // Inside the emulated external region; everything else is internal
    assign ext_hit_o = (addr_i >= `EBE_EXT_LO) && (addr_i <= `EBE_EXT_HI);

endmodule // ebe_region_decode
`default_nettype wire

// ### ebe_port_emul.sv
// Decode of the emulated port instructions into data code and address release
`timescale 1ns/100ps
`default_nettype none
`include "ebe_consts.svh"

module ebe_port_emul (
    input  wire logic [2:0]             op_i,
    output logic                        is_emul_o,
    output logic                        release_addr_o,
    output logic [`EBE_DATA_W-1:0]      code_o
);

    // Code byte and address release per instruction
    always_comb begin
        is_emul_o      = 1'b1;
        release_addr_o = 1'b0;
        code_o         = `EBE_DATA_RST;
        unique case (op_i)
            ebe_pkg::OP_PAIR_ONE: begin
                code_o = `EBE_CODE_ONE;
            end
            ebe_pkg::OP_PAIR_TWO: begin
                code_o = `EBE_CODE_TWO;
            end
            ebe_pkg::OP_REL_FOUR: begin
                release_addr_o = 1'b1;
                code_o         = `EBE_CODE_FOUR;
            end
            default: begin
                is_emul_o = 1'b0;
            end
        endcase
    end

endmodule // ebe_port_emul
`default_nettype wire

// ### ebe_far_mem.sv
// Far side model: memory behind the emulation port, with a slow-device wait
`timescale 1ns/100ps
`default_nettype none

module ebe_far_mem (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [15:0] addr_i,
    input  wire logic        addr_oe_n_i,
    input  wire logic        rd_n_i,
    input  wire logic        rd_oe_n_i,
    input  wire logic        wr_n_i,
    input  wire logic        wr_oe_n_i,
    input  wire logic [7:0]  dout_i,
    input  wire logic        dout_oe_n_i,
    input  wire logic [3:0]  wait_cycles_i,
    output logic [7:0]       din_o,
    output logic             wait_n_o
);
    logic [7:0] mem_q [256];
    logic [7:0] last_q;
    logic [3:0] cnt_q;
    logic       rd_low;
    logic       wr_low;
    logic [7:0] idx;

    // Strobe levels with pull-ups when released
    assign rd_low = !rd_oe_n_i && !rd_n_i;
    assign wr_low = !wr_oe_n_i && !wr_n_i;
    assign idx    = addr_i[7:0] ^ addr_i[15:8];

    // Resolved data wire; an undriven bus shows the inverse of its last level
    assign din_o = !dout_oe_n_i ? dout_i : (rd_low ? mem_q[idx] : ~last_q);

    // Last level seen on the data wire
    always_ff @(posedge clk_i) begin
        last_q <= din_o;
    end

    // Store write data while the write strobe is low
    always_ff @(posedge clk_i) begin
        if (wr_low) begin
            mem_q[idx] <= din_o;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= 4'h0;
        end else if (addr_oe_n_i) begin
            cnt_q <= 4'h0;
        end else if (cnt_q != 4'hF) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
    // wait held low until the count has run, idle too, so the port's synchronised copy is already low
    assign wait_n_o = (cnt_q >= wait_cycles_i);
endmodule // ebe_far_mem
`default_nettype wire

// ### ebe_bus_port_test.sv
// Self-checking bench of the external bus emulation port
`timescale 1ns/100ps
`default_nettype none
`include "ebe_consts.svh"
`define EBE_CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (b)); end end

module ebe_bus_port_test;
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        req_valid_i = 1'b0;
    logic [2:0]  req_op_i = 3'h0;
    logic [15:0] req_addr_i = 16'h0000;
    logic [7:0]  req_wdata_i = 8'h00;
    logic [7:0]  pair_upper_i = 8'h00;
    logic [7:0]  pair_lower_i = 8'h00;
    logic        halt_i = 1'b0;
    logic        hold_i = 1'b0;
    logic [3:0]  wait_cycles = 4'h0;
    wire         req_ready_o, rdata_valid_o, bus_released_o, address_bus_lines_oe_n_o;
    wire         data_bus_lines_oe_n_o, rd_n_o, rd_oe_n_o, wr_n_o, wr_oe_n_o, wait_n_i;
    wire         opcode_fetch_indicator_o, external_region_flag_n_o, emulation_strobe_o;
    wire [7:0]   rdata_o, data_bus_lines_i, data_bus_lines_o;
    wire [15:0]  address_bus_lines_o;
    int          fail_count = 0;
    int          checked = 0;
    int          lat, rd_low, strobe_n, wr_bad;
    logic [15:0] cap_addr;
    logic        cap_aoe, cap_ext, cap_fch, cap_doe;
    logic [7:0]  cap_dout, cap_rdata;

    ebe_bus_port ebe_bus_port_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i),
        .req_ready_o(req_ready_o), .req_op_i(req_op_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
        .pair_upper_i(pair_upper_i), .pair_lower_i(pair_lower_i), .halt_i(halt_i), .hold_i(hold_i),
        .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o), .bus_released_o(bus_released_o),
        .address_bus_lines_o(address_bus_lines_o), .address_bus_lines_oe_n_o(address_bus_lines_oe_n_o),
        .data_bus_lines_i(data_bus_lines_i), .data_bus_lines_o(data_bus_lines_o),
        .data_bus_lines_oe_n_o(data_bus_lines_oe_n_o), .rd_n_o(rd_n_o), .rd_oe_n_o(rd_oe_n_o),
        .wr_n_o(wr_n_o), .wr_oe_n_o(wr_oe_n_o), .wait_n_i(wait_n_i),
        .opcode_fetch_indicator_o(opcode_fetch_indicator_o),
        .external_region_flag_n_o(external_region_flag_n_o), .emulation_strobe_o(emulation_strobe_o));

    ebe_far_mem ebe_far_mem_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(address_bus_lines_o),
        .addr_oe_n_i(address_bus_lines_oe_n_o), .rd_n_i(rd_n_o), .rd_oe_n_i(rd_oe_n_o), .wr_n_i(wr_n_o),
        .wr_oe_n_i(wr_oe_n_o), .dout_i(data_bus_lines_o), .dout_oe_n_i(data_bus_lines_oe_n_o),
        .wait_cycles_i(wait_cycles), .din_o(data_bus_lines_i), .wait_n_o(wait_n_i));

    always #25 clk_i = ~clk_i;

    // One bus cycle, observed at falling edges until the port is idle again
    task automatic do_req(input logic [2:0] op, input logic [15:0] addr, input logic [7:0] wd);
        int c;
        logic done;
        c = 0;
        lat = 0;
        rd_low = 0;
        strobe_n = 0;
        wr_bad = 0;
        done = 1'b0;
        @(posedge clk_i);
        req_valid_i <= 1'b1;
        req_op_i    <= op;
        req_addr_i  <= addr;
        req_wdata_i <= wd;
        @(negedge clk_i);
        while (req_ready_o !== 1'b1 && c < 50) begin
            c++;
            @(negedge clk_i);
        end
        @(posedge clk_i);
        req_valid_i <= 1'b0;
        c = 0;
        while (!done) begin
            @(negedge clk_i);
            c++;
            if (c == 1) begin
                cap_addr = address_bus_lines_o;
                cap_aoe  = address_bus_lines_oe_n_o;
                cap_ext  = external_region_flag_n_o;
                cap_fch  = opcode_fetch_indicator_o;
                cap_doe  = data_bus_lines_oe_n_o;
                cap_dout = data_bus_lines_o;
            end
            if (rd_n_o === 1'b0) rd_low++;
            if (emulation_strobe_o === 1'b1) strobe_n++;
            if (wr_n_o === 1'b0 && (data_bus_lines_oe_n_o !== 1'b0 || data_bus_lines_o !== wd)) wr_bad++;
            if (rdata_valid_o === 1'b1 && lat == 0) begin
                lat = c;
                cap_rdata = rdata_o;
            end
            done = (c >= 4 && req_ready_o === 1'b1 && (lat > 0 || op > 3'h1)) || c > 40;
        end
        `EBE_CHK(c > 40, 1'b0)
    endtask

    // Bus lines released while reset is held
    task automatic t_reset();
        @(negedge clk_i);
        `EBE_CHK(bus_released_o, 1'b1)
        `EBE_CHK(rd_oe_n_o, 1'b1)
        `EBE_CHK(wr_oe_n_o, 1'b1)
        `EBE_CHK(external_region_flag_n_o, 1'b1)
        $display("test reset done");
    endtask

    // Write then read back at the region boundaries
    task automatic t_region();
        logic [15:0] tab [5] = '{16'h0000, 16'h0FFF, 16'h1000, 16'hFF7F, 16'hFF80};
        logic        external_region_flag;
        for (int i = 0; i < 5; i++) begin
            external_region_flag = !(tab[i] >= `EBE_EXT_LO && tab[i] <= `EBE_EXT_HI);
            do_req(ebe_pkg::OP_WRITE, tab[i], tab[i][7:0] ^ 8'h5A);
            `EBE_CHK(cap_ext, external_region_flag)
            `EBE_CHK(cap_aoe, 1'b0)
            `EBE_CHK(cap_addr, tab[i])
            `EBE_CHK(cap_doe, 1'b0)
            `EBE_CHK(wr_bad, 0)
            do_req(ebe_pkg::OP_READ, tab[i], 8'h00);
            `EBE_CHK(cap_ext, external_region_flag)
            `EBE_CHK(cap_fch, 1'b0)
            `EBE_CHK(rd_low > 0, 1'b1)
            `EBE_CHK(cap_rdata, tab[i][7:0] ^ 8'h5A)
        end
        do_req(ebe_pkg::OP_FETCH, 16'h0FFF, 8'h00);
        `EBE_CHK(cap_fch, 1'b1)
        `EBE_CHK(cap_rdata, 8'hFF ^ 8'h5A)
        $display("test region done");
    endtask

    // A slow device stretches reads and writes
    task automatic t_wait();
        int lat0;
        int rd0;
        do_req(ebe_pkg::OP_WRITE, 16'h2345, 8'hC3);
        lat0 = lat;
        do_req(ebe_pkg::OP_READ, 16'h2345, 8'h00);
        lat0 = lat;
        rd0 = rd_low;
        `EBE_CHK(lat, 5)
        wait_cycles <= 4'h4;
        do_req(ebe_pkg::OP_WRITE, 16'h2346, 8'h96);
        `EBE_CHK(wr_bad, 0)
        do_req(ebe_pkg::OP_READ, 16'h2345, 8'h00);
        `EBE_CHK(lat > lat0, 1'b1)
        `EBE_CHK(rd_low > rd0, 1'b1)
        `EBE_CHK(cap_rdata, 8'hC3)
        wait_cycles <= 4'h0;
        do_req(ebe_pkg::OP_READ, 16'h2346, 8'h00);
        `EBE_CHK(cap_rdata, 8'h96)
        $display("test wait done");
    endtask

    // The three emulated port instructions, one after another with idle cycles between
    task automatic t_port();
        logic [7:0] code [3] = '{`EBE_CODE_ONE, `EBE_CODE_TWO, `EBE_CODE_FOUR};
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_i);
            pair_upper_i <= 8'hA5 + 8'(i);
            pair_lower_i <= 8'h3C - 8'(i);
            do_req(3'h3 + 3'(i), 16'h1234, 8'h00);
            `EBE_CHK(cap_dout, code[i])
            `EBE_CHK(cap_doe, 1'b0)
            `EBE_CHK(strobe_n, 1)
            `EBE_CHK(cap_aoe, i == 2)
            if (i < 2) `EBE_CHK(cap_addr, {8'hA5 + 8'(i), 8'h3C - 8'(i)})
        end
        $display("test port done");
    endtask

    // Halt and hold park the strobes
    task automatic t_park();
        for (int i = 0; i < 2; i++) begin
            @(posedge clk_i);
            halt_i <= (i == 0);
            hold_i <= (i == 1);
            repeat (3) @(negedge clk_i);
            `EBE_CHK(rd_oe_n_o, 1'b1)
            `EBE_CHK(wr_oe_n_o, 1'b1)
            `EBE_CHK(req_ready_o, 1'b0)
            `EBE_CHK(bus_released_o, 1'b1)
            @(posedge clk_i);
            halt_i <= 1'b0;
            hold_i <= 1'b0;
            repeat (3) @(negedge clk_i);
            `EBE_CHK(rd_oe_n_o, 1'b0)
            `EBE_CHK(bus_released_o, 1'b0)
        end
        $display("test park done");
    endtask

    // Counts, verdict and end of run
    task automatic print_verdict();
        $display("checked %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (11) @(posedge clk_i);
        t_reset();
        @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_region();
        t_wait();
        t_port();
        t_park();
        print_verdict();
    end

    // Watchdog
    initial begin
        #(50 * 5000);
        fail_count++;
        print_verdict();
    end
endmodule // ebe_bus_port_test
`default_nettype wire
